// ==== dpr_pkg.sv ====
/*
 * Shared constants and types of the defective pixel replacer.
 * Assumes every user of it names items as dpr_pkg::name, without import.
 */
package dpr_pkg;
    localparam int COL_W = 12;
    localparam int ROW_W = 12;
    localparam int PIX_W = 10;
    localparam int MAP_DEPTH = 2048;
    localparam int MAP_AW = 11;
    localparam int MAX_COLS = 4096;
    localparam int WIN_LEN = 5;
    localparam int WIN_CENTRE = 2;
    localparam logic [1:0] FLUSH_COUNT = 2'h3;
    localparam logic BANK_FACTORY = 1'h0;
    localparam logic BANK_USER = 1'h1;
    localparam logic [MAP_AW:0] MAP_LEN_RESET = 12'h000;

    typedef struct packed {
        logic             v;
        logic             bad;
        logic             sof;
        logic             sol;
        logic             eol;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [PIX_W-1:0] data;
    } dpr_slot_t;
endpackage

// ==== dpr_map_if.sv ====
/*
 * Carrier between the replacer core and its bad pixel table.
 * Assumes one clock; the lookup answer is combinational in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
interface dpr_map_if;
    logic                       look_valid;
    logic                       look_sof;
    logic [dpr_pkg::COL_W-1:0]  look_col;
    logic [dpr_pkg::ROW_W-1:0]  look_row;
    logic                       look_bad;
    logic                       map_sel;
    logic                       load_en;
    logic                       load_bank;
    logic [dpr_pkg::MAP_AW-1:0] load_addr;
    logic [dpr_pkg::COL_W-1:0]  load_col;
    logic [dpr_pkg::ROW_W-1:0]  load_row;
    logic                       load_len_we;
    logic [dpr_pkg::MAP_AW:0]   load_len;

    modport core (output look_valid, look_sof, look_col, look_row, map_sel,
                  output load_en, load_bank, load_addr, load_col, load_row,
                  output load_len_we, load_len, input look_bad);
    modport table_side (input look_valid, look_sof, look_col, look_row, map_sel,
                        input load_en, load_bank, load_addr, load_col, load_row,
                        input load_len_we, load_len, output look_bad);
endinterface
`default_nettype wire

// ==== dpr_map.sv ====
/*
 * Bad pixel table with a factory bank and a user bank, scanned in raster order.
 * Assumes entries of each bank are loaded sorted by row, then column.
 */
`timescale 1ns/1ps
`default_nettype none
module dpr_map #(
    parameter int DEPTH = dpr_pkg::MAP_DEPTH
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    dpr_map_if.table_side      mi
);
    localparam int KW = dpr_pkg::ROW_W + dpr_pkg::COL_W;

    logic [KW-1:0]            entries [2][DEPTH];
    logic [dpr_pkg::MAP_AW:0] len_q [2];
    logic [dpr_pkg::MAP_AW:0] ptr_q;
    logic [dpr_pkg::MAP_AW:0] ptr_eff;
    logic                     bank_q;
    logic                     bank_eff;
    logic [KW-1:0]            key;
    logic [KW-1:0]            ent;
    logic                     live;

    always_ff @(posedge clk) begin
        if (mi.load_en) begin
            entries[mi.load_bank][mi.load_addr] <= {mi.load_row, mi.load_col};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            len_q[0] <= dpr_pkg::MAP_LEN_RESET;
            len_q[1] <= dpr_pkg::MAP_LEN_RESET;
        end else if (mi.load_len_we) begin
            len_q[mi.load_bank] <= mi.load_len;
        end
    end

    // bank chosen at frame start and held for the frame, so a switch never tears an image.
    assign bank_eff = (mi.look_valid && mi.look_sof) ? mi.map_sel : bank_q;
    assign ptr_eff  = (mi.look_valid && mi.look_sof) ? '0 : ptr_q;
    assign key      = {mi.look_row, mi.look_col};
    assign ent      = entries[bank_eff][ptr_eff[dpr_pkg::MAP_AW-1:0]];
    assign live     = (ptr_eff < len_q[bank_eff]);

    // match by row and column from the upper left origin
    assign mi.look_bad = mi.look_valid && live && (ent == key);

    // One step per cycle: a duplicate entry costs one cycle of scan and may mask
    // a bad pixel that directly follows it in the line.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q  <= '0;
            bank_q <= dpr_pkg::BANK_FACTORY;
        end else begin
            bank_q <= bank_eff;
            if (live && (ent < key || (mi.look_valid && ent == key))) begin
                ptr_q <= ptr_eff + 1'b1;
            end else begin
                ptr_q <= ptr_eff;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dpr_top.sv ====
/*
 * Defective pixel replacer on a raster pixel stream, monochrome or Bayer.
 * Assumes the source cannot stall, marks frame and line starts and line ends,
 * and leaves at least two idle cycles after each line end before the next frame.
 */
//
// Overview of operation
// - A bad pixel is found by its column and row counted from the upper left pixel.
// - The table holds up to 2048 bad pixel coordinates.
// - Replacement uses one table, the factory one or the user one, picked by a select.
// - 8-bit and 10-bit pixels are handled alike with the same coordinates.
// - If the previous pixel is bad or absent, the next pixel of the line is used if it is good.
// - If the previous pixel is good, its value replaces the bad pixel.
// - Monochrome with bad line neighbours takes the same column of the previous line.
// - If every candidate is bad, the pixel passes unchanged.
// - Bayer mode uses only candidates of the same colour, two columns away.
`timescale 1ns/1ps
`default_nettype none
module dpr_top #(
    parameter int PIX_W    = dpr_pkg::PIX_W,
    parameter int MAX_COLS = dpr_pkg::MAX_COLS,
    parameter int DEPTH    = dpr_pkg::MAP_DEPTH
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       in_valid,
    input  wire logic [PIX_W-1:0]           in_data,
    input  wire logic                       in_sof,
    input  wire logic                       in_sol,
    input  wire logic                       in_eol,
    input  wire logic                       map_sel,
    input  wire logic                       bayer_en,
    input  wire logic                       load_en,
    input  wire logic                       load_bank,
    input  wire logic [dpr_pkg::MAP_AW-1:0] load_addr,
    input  wire logic [dpr_pkg::COL_W-1:0]  load_column_position,
    input  wire logic [dpr_pkg::ROW_W-1:0]  load_row_position,
    input  wire logic                       load_len_we,
    input  wire logic [dpr_pkg::MAP_AW:0]   load_len,
    output var  logic                       out_valid,
    output var  logic [PIX_W-1:0]           out_data,
    output var  logic                       out_sof,
    output var  logic                       out_sol,
    output var  logic                       out_eol,
    output var  logic                       out_replaced
);
    logic                      rst_meta_q;
    logic                      rst_n;
    logic [dpr_pkg::COL_W-1:0] col_q;
    logic [dpr_pkg::ROW_W-1:0] row_q;
    logic [dpr_pkg::COL_W-1:0] cur_col;
    logic [dpr_pkg::ROW_W-1:0] cur_row;
    logic [1:0]                flush_q;
    logic                      shift;
    dpr_pkg::dpr_slot_t        win_q [dpr_pkg::WIN_LEN];
    dpr_pkg::dpr_slot_t        ctr;
    dpr_pkg::dpr_slot_t        prv;
    dpr_pkg::dpr_slot_t        nxt;
    logic [PIX_W:0]            line_q [MAX_COLS];
    logic [PIX_W:0]            above;
    logic                      prv_ok;
    logic                      nxt_ok;
    logic                      above_ok;
    logic [PIX_W-1:0]          fix_data;
    logic                      fix_done;

    dpr_map_if mi ();

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // position of the arriving pixel
    // Column restarts on the frame and line marks and row on the frame mark, so a short line cannot skew the count.
    always_comb begin
        cur_col = col_q + 1'b1;
        cur_row = row_q;
        if (in_sof) begin
            cur_col = '0;
            cur_row = '0;
        end else if (in_sol) begin
            cur_col = '0;
            cur_row = row_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            col_q <= '0;
            row_q <= '0;
        end else if (in_valid) begin
            col_q <= cur_col;
            row_q <= cur_row;
        end
    end

    assign mi.look_valid  = in_valid;
    assign mi.look_sof    = in_sof;
    assign mi.look_col    = cur_col;
    assign mi.look_row    = cur_row;
    assign mi.map_sel     = map_sel;
    assign mi.load_en     = load_en;
    assign mi.load_bank   = load_bank;
    assign mi.load_addr   = load_addr;
    assign mi.load_col    = load_column_position;
    assign mi.load_row    = load_row_position;
    assign mi.load_len_we = load_len_we;
    assign mi.load_len    = load_len;

    dpr_map #(
        .DEPTH (DEPTH)
    ) u_map (
        .clk   (clk),
        .rst_n (rst_n),
        .mi    (mi)
    );

    // the window drains after a line end without new pixels.
    // Three idle shifts carry the last pixel from the entry slot through the
    // output register; one fewer would strand it until the next line arrives.
    assign shift = in_valid || (flush_q != 2'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_q <= 2'h0;
        end else if (in_valid && in_eol) begin
            flush_q <= dpr_pkg::FLUSH_COUNT;
        end else if (shift && flush_q != 2'h0) begin
            flush_q <= flush_q - 1'b1;
        end
    end

    // data width plays no part in matching; narrower pixels sit in the low bits.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dpr_pkg::WIN_LEN; i++) begin
                win_q[i] <= '0;
            end
        end else if (shift) begin
            win_q[0] <= '{v: in_valid, bad: mi.look_bad, sof: in_sof, sol: in_sol,
                          eol: in_eol, row: cur_row, col: cur_col, data: in_data};
            for (int i = 1; i < dpr_pkg::WIN_LEN; i++) begin
                win_q[i] <= win_q[i-1];
            end
        end
    end

    // same colour candidates lie two columns away.
    assign ctr = win_q[dpr_pkg::WIN_CENTRE];
    assign prv = bayer_en ? win_q[dpr_pkg::WIN_CENTRE+2] : win_q[dpr_pkg::WIN_CENTRE+1];
    assign nxt = bayer_en ? win_q[dpr_pkg::WIN_CENTRE-2] : win_q[dpr_pkg::WIN_CENTRE-1];

    // A candidate counts only if it holds a good pixel of the centre's own line;
    // the row compare is what keeps neighbours from leaking across a line break.
    function automatic logic cand_good(
        input dpr_pkg::dpr_slot_t cand,
        input dpr_pkg::dpr_slot_t centre
    );
        return cand.v && !cand.bad && (cand.row == centre.row);
    endfunction

    assign prv_ok   = cand_good(prv, ctr) && !ctr.sof;
    assign nxt_ok   = cand_good(nxt, ctr) && !nxt.sof;
    assign above    = line_q[ctr.col];
    assign above_ok = (ctr.row != '0) && !above[PIX_W] && !bayer_en;

    always_comb begin
        fix_data = ctr.data;
        fix_done = 1'b0;
        if (ctr.bad) begin
            // The previous pixel is tried first, so each pixel of a bad pair borrows outward.
            if (prv_ok) begin
                fix_data = prv.data;
                fix_done = 1'b1;
            end else if (nxt_ok) begin
                fix_data = nxt.data;
                fix_done = 1'b1;
            end else if (above_ok) begin
                fix_data = above[PIX_W-1:0];
                fix_done = 1'b1;
            end
        end
    end

    // one line of corrected output, tagged with the raw bad flag.
    // Lines wider than MAX_COLS would alias columns, so the row above would be wrong.
    always_ff @(posedge clk) begin
        if (shift && ctr.v) begin
            line_q[ctr.col] <= {ctr.bad, fix_data};
        end
    end

    // Data outputs hold between pixels; only out_valid marks a new one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid    <= 1'b0;
            out_data     <= '0;
            out_sof      <= 1'b0;
            out_sol      <= 1'b0;
            out_eol      <= 1'b0;
            out_replaced <= 1'b0;
        end else begin
            out_valid <= shift && ctr.v;
            if (shift && ctr.v) begin
                out_data     <= fix_data;
                out_sof      <= ctr.sof;
                out_sol      <= ctr.sol;
                out_eol      <= ctr.eol;
                out_replaced <= fix_done;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dpr_top_checker.sv ====
/* Port timing checker of the pixel replacer.
   Assumes it is bound onto dpr_top, with one clock. */
`timescale 1ns/1ps
`default_nettype none
module dpr_top_checker #(
    parameter int PIX_W = 10
) (
    input wire logic             clk,
    input wire logic             reset_n,
    input wire logic             in_valid,
    input wire logic             in_sof,
    input wire logic             in_sol,
    input wire logic             in_eol,
    input wire logic             load_len_we,
    input wire logic             bayer_en,
    input wire logic             out_valid,
    input wire logic [PIX_W-1:0] out_data,
    input wire logic             out_sof,
    input wire logic             out_sol,
    input wire logic             out_eol,
    input wire logic             out_replaced
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic len_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            len_q <= 1'h0;
        end else if (load_len_we) begin
            len_q <= 1'h1;
        end
    end
    sof_lat_a: assert property (in_valid && in_sof ##1 in_valid [*3] |=> out_valid && out_sof)
        else $error("sof pixel late");
    sol_lat_a: assert property (in_valid && in_sol ##1 in_valid [*3] |=> out_valid && out_sol)
        else $error("sol pixel late");
    eol_lat_a: assert property (in_valid && in_eol |-> ##4 out_valid && out_eol)
        else $error("eol pixel late");
    sof_src_a: assert property (out_valid && out_sof |-> $past(in_sof, 4) && $past(in_valid, 4))
        else $error("sof without cause");
    out_hold_a: assert property (!out_valid |-> $stable({out_data, out_sof, out_sol, out_eol}))
        else $error("output moved");
    idle_out_a: assert property (!in_valid [*5] |-> !out_valid)
        else $error("output from nothing");
    map_gate_a: assert property (out_replaced |-> len_q)
        else $error("replaced with empty table");
    rst_out_a: assert property ($rose(reset_n) |-> !out_valid && !out_replaced)
        else $error("output during reset");
    cover property (out_valid && out_replaced && !bayer_en);
    cover property (out_valid && out_replaced && bayer_en);
    cover property (load_len_we);
endmodule
bind dpr_top dpr_top_checker #(.PIX_W(PIX_W)) i_chk (
    .clk(clk), .reset_n(reset_n), .in_valid(in_valid), .in_sof(in_sof),
    .in_sol(in_sol), .in_eol(in_eol), .load_len_we(load_len_we), .bayer_en(bayer_en),
    .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof), .out_sol(out_sol),
    .out_eol(out_eol), .out_replaced(out_replaced)
);
`default_nettype wire

// ==== dpr_src.sv ====
/* Sensor side pixel source of the replacer bench.
   Assumes the bench owns the clock and calls send_frame. */
`timescale 1ns/1ps
`default_nettype none
module dpr_src #(
    parameter int PIX_W = 10
) (
    input  wire logic             clk,
    output var  logic             v,
    output var  logic             sof,
    output var  logic             sol,
    output var  logic             eol,
    output var  logic [PIX_W-1:0] d
);
    initial begin
        v = 1'h0;
        sof = 1'h0;
        sol = 1'h0;
        eol = 1'h0;
        d = '0;
    end
    // raster order from the upper left.
    task automatic send_frame(input int h, input int w);
        for (int r = 0; r < h; r++) begin
            for (int c = 0; c < w; c++) begin
                @(posedge clk);
                #1;
                v = 1'h1;
                sof = (r == 0 && c == 0);
                sol = (c == 0);
                eol = (c == w - 1);
                d = PIX_W'(r * 32 + c + 1);
            end
        end
        @(posedge clk);
        #1;
        v = 1'h0;
        // Idle data is inverted so a stale pixel cannot pass as valid.
        d = ~d;
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== dpr_top_tb_top.sv ====
/* Self-checking bench of the pixel replacer.
   Assumes dpr_pkg, dpr_src and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dpr_top_tb_top;
    localparam int W = 8;
    localparam int H = 3;
    localparam int PW = dpr_pkg::PIX_W;
    logic                       clk, reset_n, v, sof, sol, eol, map_sel, bayer_en;
    logic                       load_en, load_bank, load_len_we;
    logic                       out_valid, out_sof, out_sol, out_eol, out_replaced;
    logic [PW-1:0]              d, out_data;
    logic [dpr_pkg::MAP_AW-1:0] load_addr;
    logic [dpr_pkg::COL_W-1:0]  lcol;
    logic [dpr_pkg::ROW_W-1:0]  lrow;
    logic [dpr_pkg::MAP_AW:0]   load_len;
    logic                       bad [2][H][W];
    logic [PW-1:0]              exp_q [$];
    logic                       rep_q [$];
    logic [2:0]                 flg_q [$];
    int                         num_errors, tests_run, cyc;
    dpr_top i_dut (.clk(clk), .reset_n(reset_n), .in_valid(v), .in_data(d), .in_sof(sof),
        .in_sol(sol), .in_eol(eol), .map_sel(map_sel), .bayer_en(bayer_en), .load_en(load_en),
        .load_bank(load_bank), .load_addr(load_addr), .load_column_position(lcol),
        .load_row_position(lrow), .load_len_we(load_len_we), .load_len(load_len),
        .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof), .out_sol(out_sol),
        .out_eol(out_eol), .out_replaced(out_replaced));
    dpr_src #(.PIX_W(PW)) i_src (.clk(clk), .v(v), .sof(sof), .sol(sol), .eol(eol), .d(d));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic fail(input string m);
        num_errors++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic chk_pix(input logic [PW-1:0] g, input logic [PW-1:0] e);
        tests_run++;
        if (g !== e) fail("pixel value");
    endtask
    task automatic chk_bit(input logic g, input logic e);
        tests_run++;
        if (g !== e) fail("flag value");
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            fail("timeout");
            wrap_up();
        end
        if (out_valid === 1'h1 && exp_q.size() == 0) fail("extra pixel");
        else if (out_valid === 1'h1) begin
            chk_pix(out_data, exp_q.pop_front());
            chk_bit(out_replaced, rep_q.pop_front());
            chk_bit({out_sof, out_sol, out_eol} === flg_q.pop_front(), 1'h1);
        end
    end
    task automatic load(input logic b, input int a, input int r, input int c);
        @(posedge clk);
        #1;
        load_en = 1'h1;
        load_bank = b;
        load_addr = dpr_pkg::MAP_AW'(a);
        lrow = dpr_pkg::ROW_W'(r);
        lcol = dpr_pkg::COL_W'(c);
        if (r < H) bad[b][r][c] = 1'h1;
        @(posedge clk);
        #1;
        load_en = 1'h0;
    endtask
    task automatic set_len(input logic b, input int n);
        @(posedge clk);
        #1;
        load_len_we = 1'h1;
        load_bank = b;
        load_len = (dpr_pkg::MAP_AW + 1)'(n);
        @(posedge clk);
        #1;
        load_len_we = 1'h0;
    endtask
    task automatic run_frame(input logic sel, input logic bay);
        logic [PW-1:0] o [H][W];
        logic [PW-1:0] x;
        logic          rp;
        int            k;
        k = bay ? 2 : 1;
        for (int r = 0; r < H; r++) begin
            for (int c = 0; c < W; c++) begin
                x = PW'(r * 32 + c + 1);
                rp = bad[sel][r][c];
                if (rp && c >= k && !bad[sel][r][c-k]) x = PW'(r * 32 + c - k + 1);
                else if (rp && c + k < W && !bad[sel][r][c+k]) x = PW'(r * 32 + c + k + 1);
                else if (rp && !bay && r > 0 && !bad[sel][r-1][c]) x = o[r-1][c];
                else rp = 1'h0;
                o[r][c] = x;
                exp_q.push_back(x);
                rep_q.push_back(rp);
                flg_q.push_back({r == 0 && c == 0, c == 0, c == W - 1});
            end
        end
        @(posedge clk);
        #1;
        map_sel = sel;
        bayer_en = bay;
        i_src.send_frame(H, W);
        for (k = 0; k < 50 && exp_q.size() != 0; k++) @(posedge clk);
        chk_bit(exp_q.size() == 0, 1'h1);
    endtask
    task automatic t_empty();
        run_frame(1'h1, 1'h0);
    endtask
    task automatic t_factory();
        for (int i = 0; i < 2048; i++) load(1'h0, i, i == 0 ? 1 : 3 + i / 8, i == 0 ? 1 : i % 8);
        set_len(1'h0, 2048);
        run_frame(1'h0, 1'h0);
    endtask
    task automatic t_user();
        int ul [11] = '{0, 3, 5, 6, 7, 10, 11, 12, 21, 22, 23};
        for (int i = 0; i < 11; i++) load(1'h1, i, ul[i] / 8, ul[i] % 8);
        set_len(1'h1, 11);
        run_frame(1'h1, 1'h0);
    endtask
    task automatic t_bayer();
        run_frame(1'h1, 1'h1);
    endtask
    initial begin
        {reset_n, map_sel, bayer_en, load_en, load_bank, load_len_we} = 6'h00;
        {load_addr, lcol, lrow, load_len} = '0;
        {num_errors, tests_run, cyc} = '0;
        bad = '{default: 1'h0};
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'h1;
        repeat (4) @(posedge clk);
        t_empty();
        t_factory();
        t_user();
        t_bayer();
        wrap_up();
    end
endmodule
`default_nettype wire
